// >>> hw/shunt_adc_pkg.sv
/*
  Shared constants and types for the shunt current converter control block:
  register indices, field positions, conversion timing, mode and request types.
  Assumes a 100 MHz system clock and a 16-bit register space addressed by index.
*/
package shunt_adc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // Register indices
  localparam logic [ADDR_W-1:0] OFS_OPERATING_MODE  = 7'h01;
  localparam logic [ADDR_W-1:0] OFS_FET_DRIVER      = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_ADC_OPERATION   = 7'h0C;
  localparam logic [ADDR_W-1:0] OFS_GPIO1_CONTROL   = 7'h0D;
  localparam logic [ADDR_W-1:0] OFS_GPIO2_CONTROL   = 7'h0E;
  localparam logic [ADDR_W-1:0] OFS_GPIO_OUTPUT     = 7'h0F;
  localparam logic [ADDR_W-1:0] OFS_ADC_CONTROL_ONE = 7'h18;
  localparam logic [ADDR_W-1:0] OFS_DONE_STATUS     = 7'h1C;
  localparam logic [ADDR_W-1:0] OFS_ALARM_STATUS    = 7'h21;
  localparam logic [ADDR_W-1:0] OFS_FAST_RESULT     = 7'h47;
  localparam logic [ADDR_W-1:0] OFS_SLOW_RESULT     = 7'h48;

  // Field positions
  localparam int BIT_CONTINUOUS      = 15;
  localparam int BIT_VOLTAGE_LATCH   = 0;
  localparam int BIT_FAST_LATCH      = 1;
  localparam int BIT_SLOW_LATCH      = 2;
  localparam int BIT_ONE_SHOT        = 4;
  localparam int BIT_PIN_DISABLE     = 1;
  localparam int SEL_LSB             = 8;
  localparam int SEL_MSB             = 11;
  localparam int BIT_FAST_ENABLE     = 0;
  localparam int BIT_SLOW_ENABLE     = 1;
  localparam int BIT_SERIALISE       = 4;
  localparam int BIT_SLOW_SWITCH     = 12;
  localparam int BIT_FAST_SWITCH     = 13;
  localparam int BIT_FAST_DONE       = 6;
  localparam int BIT_SLOW_DONE       = 7;

  localparam logic [3:0] PIN_ONE_FUNC_IRQ = 4'h3;
  localparam logic [3:0] PIN_TWO_FUNC_IRQ = 4'h4;

  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

  // Timing
  localparam real CLK_PERIOD_NS      = 10.0;
  localparam real FAST_CONV_TIME_MS  = 0.81;
  localparam real SLOW_PERIOD_MS     = 250.0;
  localparam int  FAST_CONV_CYCLES   = int'(FAST_CONV_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  SLOW_PERIOD_CYCLES = int'(SLOW_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  CNT_W              = 25;

  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_LOW_POWER,
    MODE_STANDBY,
    MODE_SLEEP,
    MODE_SHUTDOWN
  } power_mode_type;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

endpackage

// >>> hw/shunt_current_adc_control.sv
/*
  Control and sequencing of the fast and slow shunt current converters:
  enables, continuous and one-shot start, done flags, result latching,
  conversion interrupts on the two general-purpose pins, serialisation.
  Assumes register requests, the power mode, the voltage slot strobes and the
  converter sample words all come from logic on mclk.
*/
`timescale 1ns/1ps

// Operation
// - Fast conversion only in active mode with fast enable and fast switch set.
// - Fast conversion starts at next voltage slot, lasting about 0.81 ms.
// - Completed fast conversion sets fast done flag, status bit 6.
// - Fast latch request copies fast data to result register, then self-clears.
// - Fast done flag clears only on writing one; zero leaves it.
// - Slow accumulator runs in active, low-power, standby when enabled; 250 ms periods.
// - Slow period end raises second interrupt and sets slow done flag.
// - Slow latch copies data, drops second interrupt, self-clears.
// - Slow done flag clears only on writing one.
// - One-shot with serialise set holds slow converter in reset during fast conversion.
// - Serialise clear lets slow and fast convert together without reset.
// - Pin one carries first interrupt when select is 0011 and not disabled.
// - Pin two carries second interrupt when select is 0100 and not disabled.
// - Continuous bit starts repeated cycles with fast conversions following voltage.
// - One-shot trigger starts one measurement and self-clears on completion.
// - Routed first interrupt goes high when fast conversion completes.
// - First interrupt is shared with voltage; voltage latch request clears it.
// - Results are 16-bit two's complement, 0x7FFF top, 0x8000 at -180 mV.
module shunt_current_adc_control #(
  parameter int FAST_CYCLES = shunt_adc_pkg::FAST_CONV_CYCLES,
  parameter int SLOW_CYCLES = shunt_adc_pkg::SLOW_PERIOD_CYCLES
) (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire shunt_adc_pkg::reg_req_type     reg_req,
  output logic [shunt_adc_pkg::DATA_W-1:0]    rd_data,
  output logic                                rd_valid,
  input  wire shunt_adc_pkg::power_mode_type  power_mode,
  input  wire logic                           voltage_slot_start,
  input  wire logic                           voltage_cycle_done,
  input  wire logic [shunt_adc_pkg::DATA_W-1:0] fast_sample,
  input  wire logic [shunt_adc_pkg::DATA_W-1:0] slow_sample,
  output logic                                fast_adc_run,
  output logic                                slow_adc_run,
  output logic                                slow_adc_reset,
  output logic                                pin_one_out,
  output logic                                pin_one_oe,
  output logic                                pin_two_out,
  output logic                                pin_two_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Types, functions and declarations

  typedef enum logic {
    FAST_IDLE,
    FAST_CONVERT
  } fast_state_type;

  typedef enum logic [1:0] {
    SLOW_OFF,
    SLOW_HELD,
    SLOW_INTEGRATE
  } slow_state_type;

  function automatic logic wrote_one(input shunt_adc_pkg::reg_req_type req,
                                     input logic [shunt_adc_pkg::ADDR_W-1:0] addr,
                                     input int idx);
    wrote_one = req.write && (req.addr == addr) && req.wdata[idx];
  endfunction

  localparam logic [shunt_adc_pkg::CNT_W-1:0] FAST_LAST = shunt_adc_pkg::CNT_W'(FAST_CYCLES - 1);
  localparam logic [shunt_adc_pkg::CNT_W-1:0] SLOW_LAST = shunt_adc_pkg::CNT_W'(SLOW_CYCLES - 1);
  localparam logic [shunt_adc_pkg::CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [shunt_adc_pkg::CNT_W-1:0] CNT_ONE   = shunt_adc_pkg::CNT_W'(1);

  logic [shunt_adc_pkg::DATA_W-1:0] operating_mode_control;
  logic [shunt_adc_pkg::DATA_W-1:0] gpio1_control;
  logic [shunt_adc_pkg::DATA_W-1:0] gpio2_control;
  logic [shunt_adc_pkg::DATA_W-1:0] adc_control_one;
  logic [shunt_adc_pkg::DATA_W-1:0] fast_current_result;
  logic [shunt_adc_pkg::DATA_W-1:0] slow_current_result;
  logic [shunt_adc_pkg::DATA_W-1:0] fast_conv_data;
  logic [shunt_adc_pkg::DATA_W-1:0] slow_conv_data;
  logic                             voltage_latch_request;
  logic                             fast_latch_request;
  logic                             slow_latch_request;
  logic                             one_shot_trigger;
  logic                             fast_current_done;
  logic                             slow_current_done;
  logic                             conversion_irq_first;
  logic                             conversion_irq_second;
  logic [shunt_adc_pkg::CNT_W-1:0]  fast_count;
  logic [shunt_adc_pkg::CNT_W-1:0]  slow_count;
  fast_state_type                   fast_state;
  slow_state_type                   slow_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire write_mode    = reg_req.write && (reg_req.addr == shunt_adc_pkg::OFS_OPERATING_MODE);
  wire write_gpio1   = reg_req.write && (reg_req.addr == shunt_adc_pkg::OFS_GPIO1_CONTROL);
  wire write_gpio2   = reg_req.write && (reg_req.addr == shunt_adc_pkg::OFS_GPIO2_CONTROL);
  wire write_control = reg_req.write && (reg_req.addr == shunt_adc_pkg::OFS_ADC_CONTROL_ONE);

  wire set_voltage_latch = wrote_one(reg_req, shunt_adc_pkg::OFS_ADC_OPERATION, shunt_adc_pkg::BIT_VOLTAGE_LATCH);
  wire set_fast_latch    = wrote_one(reg_req, shunt_adc_pkg::OFS_ADC_OPERATION, shunt_adc_pkg::BIT_FAST_LATCH);
  wire set_slow_latch    = wrote_one(reg_req, shunt_adc_pkg::OFS_ADC_OPERATION, shunt_adc_pkg::BIT_SLOW_LATCH);
  wire set_one_shot      = wrote_one(reg_req, shunt_adc_pkg::OFS_ADC_OPERATION, shunt_adc_pkg::BIT_ONE_SHOT);
  wire clear_fast_done   = wrote_one(reg_req, shunt_adc_pkg::OFS_DONE_STATUS, shunt_adc_pkg::BIT_FAST_DONE);
  wire clear_slow_done   = wrote_one(reg_req, shunt_adc_pkg::OFS_DONE_STATUS, shunt_adc_pkg::BIT_SLOW_DONE);

  wire [shunt_adc_pkg::DATA_W-1:0] adc_operation_word =
    shunt_adc_pkg::DATA_W'({one_shot_trigger, 1'b0, slow_latch_request, fast_latch_request,
                            voltage_latch_request});
  wire [shunt_adc_pkg::DATA_W-1:0] done_status_word =
    shunt_adc_pkg::DATA_W'({slow_current_done, fast_current_done}) << shunt_adc_pkg::BIT_FAST_DONE;

  // Registers outside this block's scope and unmapped indices read as zero
  wire [shunt_adc_pkg::DATA_W-1:0] read_word =
    (reg_req.addr == shunt_adc_pkg::OFS_OPERATING_MODE)  ? operating_mode_control :
    (reg_req.addr == shunt_adc_pkg::OFS_ADC_OPERATION)   ? adc_operation_word :
    (reg_req.addr == shunt_adc_pkg::OFS_GPIO1_CONTROL)   ? gpio1_control :
    (reg_req.addr == shunt_adc_pkg::OFS_GPIO2_CONTROL)   ? gpio2_control :
    (reg_req.addr == shunt_adc_pkg::OFS_ADC_CONTROL_ONE) ? adc_control_one :
    (reg_req.addr == shunt_adc_pkg::OFS_DONE_STATUS)     ? done_status_word :
    (reg_req.addr == shunt_adc_pkg::OFS_FAST_RESULT)     ? fast_current_result :
    (reg_req.addr == shunt_adc_pkg::OFS_SLOW_RESULT)     ? slow_current_result :
                                                           shunt_adc_pkg::RESET_WORD;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing conditions

  wire continuous_conversion = operating_mode_control[shunt_adc_pkg::BIT_CONTINUOUS];
  wire mode_active = (power_mode == shunt_adc_pkg::MODE_ACTIVE);
  wire mode_slow_ok = mode_active || (power_mode == shunt_adc_pkg::MODE_LOW_POWER) ||
                      (power_mode == shunt_adc_pkg::MODE_STANDBY);

  wire fast_path_on = mode_active && adc_control_one[shunt_adc_pkg::BIT_FAST_ENABLE] &&
                      adc_control_one[shunt_adc_pkg::BIT_FAST_SWITCH];
  wire fast_armed   = fast_path_on && (continuous_conversion || one_shot_trigger);
  wire fast_finish  = (fast_state == FAST_CONVERT) && (fast_count == FAST_LAST) && fast_path_on;

  wire one_shot_complete = fast_path_on ? fast_finish : voltage_cycle_done;
  wire one_shot_mode     = one_shot_trigger && !continuous_conversion;

  wire slow_allowed = mode_slow_ok && adc_control_one[shunt_adc_pkg::BIT_SLOW_ENABLE] &&
                      adc_control_one[shunt_adc_pkg::BIT_SLOW_SWITCH];
  // hold slow in reset while fast converts
  wire slow_hold    = adc_control_one[shunt_adc_pkg::BIT_SERIALISE] && one_shot_mode &&
                      (fast_state == FAST_CONVERT);
  wire slow_finish  = (slow_state == SLOW_INTEGRATE) && (slow_count == SLOW_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  fast_state_type                  next_fast_state;
  slow_state_type                  next_slow_state;
  logic [shunt_adc_pkg::CNT_W-1:0] next_fast_count;
  logic [shunt_adc_pkg::CNT_W-1:0] next_slow_count;

  always_comb
  begin
    next_fast_state = fast_state;
    next_fast_count = fast_count;
    case (fast_state)
      FAST_IDLE:
      begin
        next_fast_count = CNT_ZERO;
        // start at the next voltage slot
        if (fast_armed && voltage_slot_start)
        begin
          next_fast_state = FAST_CONVERT;
        end
      end
      FAST_CONVERT:
      begin
        // Dropping an enable or leaving active mode abandons the conversion
        if (!fast_path_on || fast_finish)
        begin
          next_fast_state = FAST_IDLE;
          next_fast_count = CNT_ZERO;
        end
        else
        begin
          next_fast_count = fast_count + CNT_ONE;
        end
      end
      default:
      begin
        next_fast_state = FAST_IDLE;
        next_fast_count = CNT_ZERO;
      end
    endcase
  end

  always_comb
  begin
    next_slow_count = CNT_ZERO;
    // no hold when serialise is clear
    if (!slow_allowed)
    begin
      next_slow_state = SLOW_OFF;
    end
    else if (slow_hold)
    begin
      next_slow_state = SLOW_HELD;
    end
    else
    begin
      next_slow_state = SLOW_INTEGRATE;
    end
    case (slow_state)
      SLOW_INTEGRATE:
      begin
        if (!slow_finish && (next_slow_state == SLOW_INTEGRATE))
        begin
          next_slow_count = slow_count + CNT_ONE;
        end
      end
      SLOW_OFF,
      SLOW_HELD:
      begin
        next_slow_count = CNT_ZERO;
      end
      default:
      begin
        next_slow_count = CNT_ZERO;
      end
    endcase
  end

  // Set wins over clear for every hardware-set flag
  // fast done set
  wire next_fast_done  = fast_finish || (fast_current_done && !clear_fast_done);
  wire next_slow_done  = slow_finish || (slow_current_done && !clear_slow_done);
  // shared with voltage, cleared by voltage latch
  wire next_irq_first  = fast_finish || voltage_cycle_done || (conversion_irq_first && !voltage_latch_request);
  // second interrupt dropped by slow latch
  wire next_irq_second = slow_finish || (conversion_irq_second && !slow_latch_request);
  wire next_one_shot   = set_one_shot || (one_shot_trigger && !one_shot_complete);

  wire pin_one_routed = (gpio1_control[shunt_adc_pkg::SEL_MSB:shunt_adc_pkg::SEL_LSB] ==
                         shunt_adc_pkg::PIN_ONE_FUNC_IRQ) && !gpio1_control[shunt_adc_pkg::BIT_PIN_DISABLE];
  wire pin_two_routed = (gpio2_control[shunt_adc_pkg::SEL_MSB:shunt_adc_pkg::SEL_LSB] ==
                         shunt_adc_pkg::PIN_TWO_FUNC_IRQ) && !gpio2_control[shunt_adc_pkg::BIT_PIN_DISABLE];

  ////////////////////////////////////////////////////////////////////////////////
  // Host registers

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      operating_mode_control <= shunt_adc_pkg::RESET_WORD;
      gpio1_control          <= shunt_adc_pkg::RESET_WORD;
      gpio2_control          <= shunt_adc_pkg::RESET_WORD;
      adc_control_one        <= shunt_adc_pkg::RESET_WORD;
      rd_data                <= shunt_adc_pkg::RESET_WORD;
      rd_valid               <= 1'b0;
    end
    else
    begin
      if (write_mode)
        operating_mode_control <= reg_req.wdata;
      if (write_gpio1)
        gpio1_control <= reg_req.wdata;
      if (write_gpio2)
        gpio2_control <= reg_req.wdata;
      if (write_control)
        adc_control_one <= reg_req.wdata;
      rd_data  <= reg_req.read ? read_word : shunt_adc_pkg::RESET_WORD;
      rd_valid <= reg_req.read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latch requests and results

  // A request stands for one cycle, copies on the edge that ends it, then clears;
  // well inside both the 315 ns and 48 us host waits
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      voltage_latch_request <= 1'b0;
      fast_latch_request    <= 1'b0;
      slow_latch_request    <= 1'b0;
      fast_current_result   <= shunt_adc_pkg::RESET_WORD;
      slow_current_result   <= shunt_adc_pkg::RESET_WORD;
    end
    else
    begin
      voltage_latch_request <= set_voltage_latch;
      fast_latch_request    <= set_fast_latch;
      slow_latch_request    <= set_slow_latch;
      if (fast_latch_request)
        fast_current_result <= fast_conv_data;
      if (slow_latch_request)
        slow_current_result <= slow_conv_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencers, flags and pins

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fast_state            <= FAST_IDLE;
      slow_state            <= SLOW_OFF;
      fast_count            <= CNT_ZERO;
      slow_count            <= CNT_ZERO;
      fast_conv_data        <= shunt_adc_pkg::RESET_WORD;
      slow_conv_data        <= shunt_adc_pkg::RESET_WORD;
      one_shot_trigger      <= 1'b0;
      fast_current_done     <= 1'b0;
      slow_current_done     <= 1'b0;
      conversion_irq_first  <= 1'b0;
      conversion_irq_second <= 1'b0;
      fast_adc_run          <= 1'b0;
      slow_adc_run          <= 1'b0;
      slow_adc_reset        <= 1'b0;
      pin_one_out           <= 1'b0;
      pin_one_oe            <= 1'b0;
      pin_two_out           <= 1'b0;
      pin_two_oe            <= 1'b0;
    end
    else
    begin
      fast_state            <= next_fast_state;
      slow_state            <= next_slow_state;
      fast_count            <= next_fast_count;
      slow_count            <= next_slow_count;
      // sample words are kept as signed codes, no rescaling
      if (fast_finish)
        fast_conv_data <= fast_sample;
      if (slow_finish)
        slow_conv_data <= slow_sample;
      one_shot_trigger      <= next_one_shot;
      fast_current_done     <= next_fast_done;
      slow_current_done     <= next_slow_done;
      conversion_irq_first  <= next_irq_first;
      conversion_irq_second <= next_irq_second;
      fast_adc_run          <= (next_fast_state == FAST_CONVERT);
      slow_adc_run          <= (next_slow_state == SLOW_INTEGRATE);
      slow_adc_reset        <= (next_slow_state == SLOW_HELD);
      pin_one_out           <= pin_one_routed && next_irq_first;
      pin_one_oe            <= pin_one_routed;
      pin_two_out           <= pin_two_routed && next_irq_second;
      pin_two_oe            <= pin_two_routed;
    end
  end

endmodule // shunt_current_adc_control

// >>> verif/shunt_adc_props.sv
/*
  Checker for the shunt current control block, bound to its top ports.
  Assumes inputs change just after the rising edge of mclk.
*/
`timescale 1ns/1ps
module shunt_adc_props #(
  parameter int FAST_CYCLES = 8,
  parameter int SLOW_CYCLES = 40
) (
  input wire logic                          mclk,
  input wire logic                          rst,
  input wire shunt_adc_pkg::reg_req_type    reg_req,
  input wire logic [15:0]                   rd_data,
  input wire logic                          rd_valid,
  input wire shunt_adc_pkg::power_mode_type power_mode,
  input wire logic                          voltage_slot_start,
  input wire logic                          voltage_cycle_done,
  input wire logic [15:0]                   fast_sample,
  input wire logic [15:0]                   slow_sample,
  input wire logic                          fast_adc_run,
  input wire logic                          slow_adc_run,
  input wire logic                          slow_adc_reset,
  input wire logic                          pin_one_out,
  input wire logic                          pin_one_oe,
  input wire logic                          pin_two_out,
  input wire logic                          pin_two_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  int unsigned run_cnt;
  wire         op_wr = reg_req.write && reg_req.addr == shunt_adc_pkg::OFS_ADC_OPERATION;
  ////////////////////////////////////////////////////////////////
  // Counts high cycles of a conversion; an abort restarts it
  always_ff @(posedge mclk)
    if (rst || !fast_adc_run) run_cnt <= 0;
    else run_cnt <= run_cnt + 1;
  ////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_req.read |=> rd_valid) else $error("read not answered");
  a_valid_cause: assert property (rd_valid |-> $past(reg_req.read)) else $error("stray read valid");
  a_idle_data: assert property (!rd_valid |-> rd_data == 16'h0000) else $error("read data not zero");
  a_fast_start: assert property ($rose(fast_adc_run) |-> $past(voltage_slot_start) &&
    $past(power_mode) == shunt_adc_pkg::MODE_ACTIVE) else $error("fast start without slot");
  a_fast_length: assert property (run_cnt <= FAST_CYCLES) else $error("fast conversion too long");
  a_fast_irq: assert property ($fell(fast_adc_run) && run_cnt == FAST_CYCLES && pin_one_oe
    |-> ##[0:2] pin_one_out) else $error("pin one not raised");
  a_pin_one_gate: assert property (pin_one_out |-> pin_one_oe) else $error("pin one unrouted");
  a_pin_two_gate: assert property (pin_two_out |-> pin_two_oe) else $error("pin two unrouted");
  a_irq_two_clear: assert property (op_wr && reg_req.wdata[2] |-> ##[1:3] !pin_two_out)
    else $error("pin two not cleared");
  a_irq_one_clear: assert property (op_wr && reg_req.wdata[0] && !fast_adc_run &&
    !voltage_cycle_done |-> ##[1:3] !pin_one_out) else $error("pin one not cleared");
  a_serial_reset: assert property (slow_adc_reset |-> fast_adc_run || $past(fast_adc_run))
    else $error("slow held without fast");
endmodule // shunt_adc_props

// >>> verif/host_model.sv
/*
  Host model: issues one register request at a time on reg_req.
  Assumes the block answers a read one cycle after taking it.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic                  mclk,
  output shunt_adc_pkg::reg_req_type reg_req,
  input  wire logic [15:0]           rd_data,
  input  wire logic                  rd_valid
);
  initial reg_req = '0;
  // clears and starts are writes of one
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    // Idle data lines show a changed pattern, never the last word
    reg_req <= '{1'b0, 1'b0, a, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, a, 16'h5a5a};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, a, 16'ha5a5};
    @(posedge mclk);
    d = rd_valid === 1'b1 ? rd_data : 16'hxxxx;
  endtask
  // poll until the latch bit reads zero
  task automatic latch(input int b);
    logic [15:0] d;
    wr(shunt_adc_pkg::OFS_ADC_OPERATION, 16'h0001 << b);
    repeat (6)
    begin
      rd(shunt_adc_pkg::OFS_ADC_OPERATION, d);
      if (d[b] === 1'b0) break;
    end
  endtask
endmodule // host_model

// >>> verif/testbench.sv
/*
  Self-checking bench for the shunt current control block.
  Assumes short conversion counts: 8 cycles fast, 40 cycles slow.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
  localparam int         FC = 8;
  localparam int         SC = 40;
  localparam logic [6:0] OP = shunt_adc_pkg::OFS_ADC_OPERATION;
  localparam logic [6:0] CT = shunt_adc_pkg::OFS_ADC_CONTROL_ONE;
  localparam logic [6:0] DN = shunt_adc_pkg::OFS_DONE_STATUS;
  logic mclk, rst, voltage_slot_start, rd_valid, fast_adc_run, slow_adc_run, slow_adc_reset;
  logic pin_one_out, pin_one_oe, pin_two_out, pin_two_oe, voltage_cycle_done;
  logic [15:0]                    rd_data, fast_sample, slow_sample, d, s0;
  shunt_adc_pkg::reg_req_type     reg_req;
  shunt_adc_pkg::power_mode_type  power_mode;
  int                             mismatches, n_compared, cycles, i;
  logic [31:0]                    seed;
  shunt_current_adc_control #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) uut (.mclk(mclk), .rst(rst),
    .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid), .power_mode(power_mode),
    .voltage_slot_start(voltage_slot_start), .voltage_cycle_done(voltage_cycle_done), .fast_sample(fast_sample),
    .slow_sample(slow_sample), .fast_adc_run(fast_adc_run), .slow_adc_run(slow_adc_run),
    .slow_adc_reset(slow_adc_reset), .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe),
    .pin_two_out(pin_two_out), .pin_two_oe(pin_two_oe));
  host_model host (.mclk(mclk), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  // Slot pulse, then a bounded wait for the conversion to begin
  task automatic slot();
    @(posedge mclk);
    voltage_slot_start <= 1'b1;
    @(posedge mclk);
    voltage_slot_start <= 1'b0;
    repeat (4) if (fast_adc_run !== 1'b1) @(posedge mclk);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hf83d_b79d;
    rst = 1'b1;
    voltage_slot_start = 1'b0;
    voltage_cycle_done = 1'b0;
    power_mode = shunt_adc_pkg::MODE_STANDBY;
    fast_sample = 16'h0000;
    slow_sample = 16'($random(seed));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    host.wr(shunt_adc_pkg::OFS_FAST_RESULT, 16'hffff);
    rchk(shunt_adc_pkg::OFS_FAST_RESULT, 16'h0000);
    host.wr(shunt_adc_pkg::OFS_GPIO1_CONTROL, 16'h0300);
    host.wr(shunt_adc_pkg::OFS_GPIO2_CONTROL, 16'h0400);
    host.wr(CT, 16'h3003);
    `CHK(pin_one_oe, 1'b1)
    `CHK(pin_two_oe, 1'b1)
    host.wr(OP, 16'h0010);
    slot();
    `CHK(fast_adc_run, 1'b0)
    // Fast path off: the voltage cycle alone ends the one-shot and raises interrupt one
    @(posedge mclk);
    voltage_cycle_done <= 1'b1;
    @(posedge mclk);
    voltage_cycle_done <= 1'b0;
    host.rd(OP, d);
    `CHK(d[4], 1'b0)
    `CHK(pin_one_out, 1'b1)
    host.wr(OP, 16'h0001);
    repeat (2 * SC) if (pin_two_out !== 1'b1) @(posedge mclk);
    `CHK(pin_two_out, 1'b1)
    rchk(DN, 16'h0080);
    host.wr(DN, 16'h0000);
    rchk(DN, 16'h0080);
    s0 = slow_sample;
    host.latch(2);
    `CHK(pin_two_out, 1'b0)
    rchk(shunt_adc_pkg::OFS_SLOW_RESULT, s0);
    slow_sample <= 16'($random(seed));
    repeat (SC + 5) @(posedge mclk);
    rchk(shunt_adc_pkg::OFS_SLOW_RESULT, s0);
    power_mode <= shunt_adc_pkg::MODE_ACTIVE;
    for (i = 0; i < 3; i++)
    begin
      s0 = i == 0 ? 16'h7fff : i == 1 ? 16'h8000 : 16'($random(seed));
      fast_sample <= s0;
      host.wr(CT, i == 2 ? 16'h3013 : 16'h3003);
      host.wr(OP, 16'h0010);
      slot();
      `CHK(fast_adc_run, 1'b1)
      // The slow hold follows the fast run by one registered stage
      @(posedge mclk);
      `CHK(slow_adc_reset, 1'(i == 2))
      `CHK(slow_adc_run, 1'(i != 2))
      repeat (FC + 4) if (fast_adc_run !== 1'b0) @(posedge mclk);
      @(posedge mclk);
      `CHK(pin_one_out, 1'b1)
      host.rd(DN, d);
      `CHK(d[6], 1'b1)
      host.rd(OP, d);
      `CHK(d[4], 1'b0)
      host.wr(DN, 16'h0000);
      host.rd(DN, d);
      `CHK(d[6], 1'b1)
      host.latch(1);
      rchk(shunt_adc_pkg::OFS_FAST_RESULT, s0);
      host.wr(DN, 16'h0040);
      host.rd(DN, d);
      `CHK(d[6], 1'b0)
      host.wr(OP, 16'h0001);
      repeat (3) @(posedge mclk);
      `CHK(pin_one_out, 1'b0)
    end
    host.wr(CT, 16'h3003);
    host.wr(shunt_adc_pkg::OFS_OPERATING_MODE, 16'h8000);
    repeat (2)
    begin
      slot();
      `CHK(fast_adc_run, 1'b1)
      repeat (FC + 4) if (fast_adc_run !== 1'b0) @(posedge mclk);
    end
    host.wr(shunt_adc_pkg::OFS_OPERATING_MODE, 16'h0000);
    end_of_test();
  end
endmodule // testbench
bind shunt_current_adc_control shunt_adc_props #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) props (
  .mclk(mclk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
  .power_mode(power_mode), .voltage_slot_start(voltage_slot_start), .voltage_cycle_done(voltage_cycle_done),
  .fast_sample(fast_sample), .slow_sample(slow_sample), .fast_adc_run(fast_adc_run),
  .slow_adc_run(slow_adc_run), .slow_adc_reset(slow_adc_reset), .pin_one_out(pin_one_out),
  .pin_one_oe(pin_one_oe), .pin_two_out(pin_two_out), .pin_two_oe(pin_two_oe));
